// ===== inc/nfh_map.svh
`ifndef NFH_MAP_SVH
`define NFH_MAP_SVH
// Operation
// - Top data line is data in word mode, host-driven byte address LSB in byte mode.
// - Chip select, output gate and write strobe are all active low.
// - At most two banks active: one programming or erasing, one being read.
// - Completion shows on done_not_busy, polling_bit and both toggle bits; the host watches only done_not_busy and the bit 6 toggle.
// - Commands go by plain write cycles; array reads behave like ROM reads.
// - Host may put the device in standby when it neither reads nor writes.
// - Host writes with write strobe and chip select low, output gate high.

// ****************************************************************
// Register offsets and fields
// ****************************************************************
`define NFH_OFF_CTRL 8'h00
`define NFH_OFF_ADDR 8'h04
`define NFH_OFF_WDATA 8'h08
`define NFH_OFF_CMD 8'h0c
`define NFH_OFF_STATUS 8'h10
`define NFH_OFF_RDATA 8'h14
`define NFH_CTRL_BYTE 0
`define NFH_CTRL_PROTECT 1
`define NFH_CTRL_RESET 2
`define NFH_CMD_READ 0
`define NFH_CMD_WRITE 1
`define NFH_CMD_ARM 2
`define NFH_STAT_REFUSED 3
`define NFH_CTRL_RESET_VAL 3'h0

// ****************************************************************
// Geometry and timing
// ****************************************************************
`define NFH_WORDS 4194304
`define NFH_BYTES 8388608
`define NFH_CLK_NS 50
`define NFH_T_ACC_NS 60
`define NFH_T_WP_NS 60
`define NFH_ACC_CYC ((`NFH_T_ACC_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_WP_CYC ((`NFH_T_WP_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_SYNC_STAGES 2
`endif

// ===== inc/nfh_pkg.sv
package nfh_pkg;
    typedef enum logic [2:0] {
        NFH_ST_IDLE = 3'h0,
        NFH_ST_SETUP = 3'h1,
        NFH_ST_ACTIVE = 3'h3,
        NFH_ST_FINISH = 3'h2
    } nfh_state_t;

    typedef enum logic [1:0] {
        NFH_BANK_1 = 2'h0,
        NFH_BANK_2 = 2'h1,
        NFH_BANK_3 = 2'h2,
        NFH_BANK_4 = 2'h3
    } nfh_bank_t;
endpackage

// ===== logic/nfh_host.sv
`timescale 1ns/1ns
`include "nfh_map.svh"
module nfh_host #(
    parameter int ACC_CYC = `NFH_ACC_CYC,
    parameter int WP_CYC = `NFH_WP_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    output logic [21:0] flash_addr,
    input wire logic [15:0] flash_dq_in,
    output logic [15:0] flash_dq_out,
    output logic [15:0] flash_dq_oe,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_reset_n,
    output logic flash_byte_n,
    output logic flash_wp_n,
    input wire logic flash_done_not_busy
);
    localparam logic [3:0] RD_LAST = 4'(ACC_CYC + `NFH_SYNC_STAGES - 1);
    localparam logic [3:0] WR_LAST = 4'(WP_CYC - 1);

    nfh_pkg::nfh_state_t state;
    nfh_pkg::nfh_state_t next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic is_write;
    logic byte_mode;
    logic protect;
    logic hw_reset;
    logic [22:0] addr_q;
    logic [15:0] wdata_q;
    logic [15:0] rd_data;
    logic armed;
    logic seen_low;
    logic refused;
    logic toggled;
    logic have_prev;
    logic prev_toggle;
    logic [1:0] busy_bank;
    logic [15:0] dq_s;
    logic rdy_s;

    // ****************************************************************
    // Pin inputs pass two flip-flops before any use.
    // ****************************************************************
    nfh_sync #(.WIDTH(17)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .din({flash_done_not_busy, flash_dq_in}),
        .dout({rdy_s, dq_s})
    );

    // ****************************************************************
    // Register decode
    // ****************************************************************
    wire idle = state == nfh_pkg::NFH_ST_IDLE;
    wire sel_ctrl = reg_addr == `NFH_OFF_CTRL;
    wire sel_addr = reg_addr == `NFH_OFF_ADDR;
    wire sel_wdata = reg_addr == `NFH_OFF_WDATA;
    wire sel_cmd = reg_addr == `NFH_OFF_CMD;
    wire sel_status = reg_addr == `NFH_OFF_STATUS;
    wire sel_rdata = reg_addr == `NFH_OFF_RDATA;
    wire wr_ctrl = reg_we && sel_ctrl;
    wire wr_addr = reg_we && sel_addr && idle;
    wire wr_wdata = reg_we && sel_wdata && idle;
    wire wr_cmd = reg_we && sel_cmd && idle && !hw_reset;

    // Byte mode takes a 23-bit byte address; word mode a 22-bit word address.
    wire [21:0] word_addr = byte_mode ? addr_q[22:1] : addr_q[21:0];

    // Eight equal slices of the address: slice 0 is bank one, 7 bank four.
    wire [2:0] slice = word_addr[21:19];
    wire [1:0] tgt_bank = (slice == 3'h0) ? nfh_pkg::NFH_BANK_1 :
                          (slice == 3'h7) ? nfh_pkg::NFH_BANK_4 :
                          slice[2] ? nfh_pkg::NFH_BANK_3 : nfh_pkg::NFH_BANK_2;

    // A write may target only the bank already programming, if any.
    wire bank_clash = armed && (tgt_bank != busy_bank);
    wire req_rd = wr_cmd && reg_wdata[`NFH_CMD_READ];
    wire req_wr = wr_cmd && reg_wdata[`NFH_CMD_WRITE] && !reg_wdata[`NFH_CMD_READ];
    wire start_rd = req_rd;
    wire start_wr = req_wr && !bank_clash;
    wire refuse_wr = req_wr && bank_clash;
    wire arm_req = start_wr && reg_wdata[`NFH_CMD_ARM];
    wire clear_refused = reg_we && sel_status && reg_wdata[`NFH_STAT_REFUSED];

    // Busy bank is released once done_not_busy has gone low and risen again.
    wire release_bank = armed && seen_low && rdy_s;

    wire next_is_write = start_rd ? 1'b0 : (start_wr ? 1'b1 : is_write);
    wire capture = (state == nfh_pkg::NFH_ST_FINISH) && !is_write;
    wire [15:0] cap_data = byte_mode ? {8'h00, dq_s[7:0]} : dq_s;
    wire next_toggled = have_prev && (prev_toggle != dq_s[6]);

    // ****************************************************************
    // Sequencer for one access
    // ****************************************************************
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            nfh_pkg::NFH_ST_IDLE: begin
                next_cnt = 4'h0;
                if (start_rd || start_wr) begin
                    next_state = nfh_pkg::NFH_ST_SETUP;
                end
            end
            nfh_pkg::NFH_ST_SETUP: begin
                next_state = nfh_pkg::NFH_ST_ACTIVE;
            end
            nfh_pkg::NFH_ST_ACTIVE: begin
                if (cnt == (is_write ? WR_LAST : RD_LAST)) begin
                    next_state = nfh_pkg::NFH_ST_FINISH;
                end else begin
                    next_cnt = cnt + 4'h1;
                end
            end
            nfh_pkg::NFH_ST_FINISH: begin
                next_state = nfh_pkg::NFH_ST_IDLE;
            end
            default: begin
                next_state = nfh_pkg::NFH_ST_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // Next pin levels
    // ****************************************************************
    wire next_active = next_state != nfh_pkg::NFH_ST_IDLE;
    // Chip select stays high between accesses, which is standby.
    wire next_ce_n = !next_active;
    wire next_oe_n = !(next_active && !next_is_write && next_state != nfh_pkg::NFH_ST_SETUP);
    // Output gate stays high for the whole write; strobe low only in ACTIVE.
    wire next_we_n = !(next_is_write && next_state == nfh_pkg::NFH_ST_ACTIVE);
    wire [15:0] width_mask = byte_mode ? 16'h00ff : 16'hffff;
    wire [15:0] drive_mask = (next_is_write && next_active) ? width_mask : 16'h0000;
    // In byte mode the top data line always carries the byte address LSB.
    wire [15:0] next_dq_oe = {drive_mask[15] | byte_mode, drive_mask[14:0]};
    wire [15:0] next_dq_out = {byte_mode ? addr_q[0] : wdata_q[15], wdata_q[14:0]};

    wire [31:0] rd_mux = sel_ctrl ? {29'h0, hw_reset, protect, byte_mode} :
                         sel_addr ? {9'h0, addr_q} :
                         sel_wdata ? {16'h0, wdata_q} :
                         sel_status ? {25'h0, busy_bank, toggled, refused, armed, rdy_s, !idle} :
                         sel_rdata ? {16'h0, rd_data} : 32'h0;

    // ****************************************************************
    // State registers
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= nfh_pkg::NFH_ST_IDLE;
            cnt <= 4'h0;
            is_write <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            is_write <= next_is_write;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            {hw_reset, protect, byte_mode} <= `NFH_CTRL_RESET_VAL;
        end else if (wr_ctrl) begin
            byte_mode <= reg_wdata[`NFH_CTRL_BYTE];
            protect <= reg_wdata[`NFH_CTRL_PROTECT];
            hw_reset <= reg_wdata[`NFH_CTRL_RESET];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            addr_q <= 23'h0;
            wdata_q <= 16'h0;
        end else begin
            if (wr_addr) begin
                addr_q <= reg_wdata[22:0];
            end
            if (wr_wdata) begin
                wdata_q <= reg_wdata[15:0];
            end
        end
    end

    // ****************************************************************
    // Read capture and completion polling
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_data <= 16'h0;
            toggled <= 1'b0;
            have_prev <= 1'b0;
            prev_toggle <= 1'b0;
        end else if (capture) begin
            rd_data <= cap_data;
            toggled <= next_toggled;
            have_prev <= 1'b1;
            prev_toggle <= dq_s[6];
        end
    end

    // The busy bank is tracked so that only one bank programs at a time.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            armed <= 1'b0;
            seen_low <= 1'b0;
            busy_bank <= 2'h0;
        end else if (arm_req) begin
            armed <= 1'b1;
            seen_low <= 1'b0;
            busy_bank <= tgt_bank;
        end else if (release_bank || hw_reset) begin
            armed <= 1'b0;
            seen_low <= 1'b0;
        end else if (armed && !rdy_s) begin
            seen_low <= 1'b1;
        end
    end

    // A refusal in the same cycle as its clear stays set.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            refused <= 1'b0;
        end else if (refuse_wr) begin
            refused <= 1'b1;
        end else if (clear_refused) begin
            refused <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_re ? rd_mux : 32'h0;
        end
    end

    // ****************************************************************
    // Pin registers
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_reset_n <= 1'b0;
            flash_byte_n <= 1'b1;
            flash_wp_n <= 1'b1;
        end else begin
            flash_ce_n <= next_ce_n;
            flash_oe_n <= next_oe_n;
            flash_we_n <= next_we_n;
            flash_reset_n <= !hw_reset;
            flash_byte_n <= !byte_mode;
            flash_wp_n <= !protect;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flash_addr <= 22'h0;
            flash_dq_out <= 16'h0;
            flash_dq_oe <= 16'h0;
        end else begin
            flash_addr <= word_addr;
            flash_dq_out <= next_dq_out;
            flash_dq_oe <= next_dq_oe;
        end
    end
endmodule

// ===== logic/nfh_sync.sv
`timescale 1ns/1ns
module nfh_sync #(
    parameter int WIDTH = 17
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;

    // ****************************************************************
    // Two-flop synchroniser; stage1 feeds only dout.
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            dout <= '0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule

// ===== verif/nfh_flash_model.sv
`timescale 1ns/1ns
module nfh_flash_model #(
    parameter int BUSY_NS = 3000
) (
    input wire logic [21:0] addr,
    input wire logic [15:0] dq,
    output logic [15:0] dq_q,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic reset_n,
    input wire logic byte_n,
    input wire logic wp_n,
    output logic done_not_busy
);
    logic [7:0] mem [int];
    logic [15:0] last = 16'h0000;
    logic prot;
    int b;
    initial done_not_busy = 1'b1;
    function automatic logic [7:0] rd(input int k);
        return mem.exists(k) ? mem[k] : 8'hff;
    endfunction
    // ****************************************************************
    // Array access
    // ****************************************************************
    assign b = int'({addr, byte_n ? 1'b0 : dq[15]});
    // Boot sectors at both ends of the array are the protected ones.
    assign prot = !wp_n && (addr < 22'h002000 || addr >= 22'h3fe000);
    always_comb begin
        if (!ce_n && !oe_n && reset_n) begin
            dq_q = {byte_n ? rd(b + 1) : ~last[15:8], rd(b)};
        end else begin
            dq_q = ~last;
        end
    end
    always @(posedge oe_n) last <= dq_q;
    always @(posedge we_n) begin
        if (!ce_n && oe_n && reset_n && done_not_busy && !prot) begin
            mem[b] = dq[7:0];
            if (byte_n) mem[b + 1] = dq[15:8];
            done_not_busy = 1'b0;
            #(BUSY_NS) done_not_busy = 1'b1;
        end
    end
endmodule

// ===== verif/nfh_host_chk.sv
`timescale 1ns/1ns
module nfh_host_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic [15:0] flash_dq_oe,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic flash_reset_n,
    input wire logic flash_byte_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ****************************************************************
    // Pin protocol
    // ****************************************************************
    chk_gate_excl: assert property (!(!flash_oe_n && !flash_we_n))
        else $error("output gate and write strobe low together");
    chk_write_pulse: assert property ($fell(flash_we_n) |-> !$past(flash_ce_n) && flash_oe_n ##1 !flash_we_n
        ##1 (flash_we_n && !flash_ce_n) ##1 flash_ce_n)
        else $error("write strobe cycle malformed");
    chk_read_pulse: assert property ($fell(flash_oe_n) |-> (!flash_oe_n && !flash_ce_n) [*5]
        ##1 (flash_oe_n && flash_ce_n))
        else $error("read cycle malformed");
    chk_read_start: assert property (reg_we && reg_addr == 8'h0c && reg_wdata[0] && flash_ce_n && flash_reset_n
        |=> !flash_ce_n && flash_oe_n ##1 !flash_oe_n)
        else $error("read command did not start a read cycle");
    chk_byte_lsb: assert property (!flash_byte_n |-> flash_dq_oe[15])
        else $error("address LSB line not driven in byte mode");
    chk_word_drive: assert property (!flash_we_n && flash_byte_n |-> flash_dq_oe == 16'hffff)
        else $error("word write does not drive all data lines");
    chk_read_float: assert property (!flash_oe_n |-> flash_dq_oe[14:0] == 15'h0000)
        else $error("host drives data lines during read");
    chk_standby_idle: assert property (flash_ce_n |-> flash_oe_n && flash_we_n)
        else $error("strobes active while deselected");
    chk_reset_pin: assert property (reg_we && reg_addr == 8'h00 && reg_wdata[2] |-> ##[1:2] !flash_reset_n)
        else $error("device reset pin not asserted");
    cov_write: cover property ($fell(flash_we_n));
    cov_byte_read: cover property ($fell(flash_oe_n) && !flash_byte_n);
    cov_reset: cover property ($fell(flash_reset_n));
endmodule
bind nfh_host nfh_host_chk i_nfh_host_chk (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_reset_n(flash_reset_n), .flash_byte_n(flash_byte_n));

// ===== verif/tb_top.sv
`timescale 1ns/1ns
`include "nfh_map.svh"
module tb_top;
    logic mclk, rst, reg_we, reg_re, ce_n, oe_n, we_n, reset_n, byte_n, wp_n, dnb;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic [21:0] flash_addr;
    logic [15:0] dq_out, dq_oe, dev_q, dq_w;
    int n_errors = 0, checks_done = 0, cyc = 0;
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    assign dq_w = (dq_oe & dq_out) | (~dq_oe & dev_q);
    nfh_host i_nfh_host (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_dq_in(dq_w), .flash_dq_out(dq_out),
        .flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_reset_n(reset_n),
        .flash_byte_n(byte_n), .flash_wp_n(wp_n), .flash_done_not_busy(dnb));
    nfh_flash_model i_nfh_flash_model (.addr(flash_addr), .dq(dq_w), .dq_q(dev_q), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .reset_n(reset_n), .byte_n(byte_n), .wp_n(wp_n), .done_not_busy(dnb));
    // ****************************************************************
    // Bus tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            n_errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge mclk);
        reg_we <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge mclk);
        reg_re <= 1'b0;
        #1 d = reg_rdata;
        @(posedge mclk);
    endtask
    task automatic idle;
        rd(`NFH_OFF_STATUS, v);
        for (int i = 0; i < 40 && v[0] !== 1'b0; i++) rd(`NFH_OFF_STATUS, v);
        chk(v & 32'h1, 32'h0);
    endtask
    task automatic ready;
        rd(`NFH_OFF_STATUS, v);
        for (int i = 0; i < 150 && v[1] !== 1'b1; i++) rd(`NFH_OFF_STATUS, v);
        chk(v & 32'h2, 32'h2);
    endtask
    task automatic access(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
        wr(`NFH_OFF_ADDR, a);
        wr(`NFH_OFF_WDATA, d);
        wr(`NFH_OFF_CMD, c);
        idle();
    endtask
    task automatic get(input logic [31:0] a, input logic [31:0] exp);
        access(a, 32'h0, 32'h1);
        rd(`NFH_OFF_RDATA, v);
        chk(v, exp);
    endtask
    task automatic ctrl(input logic [31:0] d);
        wr(`NFH_OFF_CTRL, d);
        repeat (2) @(posedge mclk);
        #1 chk({29'h0, reset_n, wp_n, byte_n}, {29'h0, ~d[2:0]});
        @(posedge mclk);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        chk({28'h0, ce_n, oe_n, we_n, reset_n}, 32'hf);
        rd(`NFH_OFF_CTRL, v);
        chk(v, 32'h0);
        rd(8'h20, v);
        chk(v, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_word;
        access(32'h000123, 32'ha5c3, 32'h2);
        ready();
        get(32'h000123, 32'ha5c3);
        $display("test word done");
    endtask
    task automatic t_byte;
        ctrl(32'h1);
        access(32'h000401, 32'h5a, 32'h2);
        ready();
        get(32'h000401, 32'h5a);
        get(32'h000400, 32'hff);
        ctrl(32'h0);
        get(32'h000200, 32'h5aff);
        $display("test byte done");
    endtask
    task automatic t_bank;
        access(32'h080000, 32'h3c3c, 32'h6);
        rd(`NFH_OFF_STATUS, v);
        chk(v & 32'h6f, 32'h24);
        get(32'h000123, 32'ha5c3);
        access(32'h200000, 32'h1111, 32'h2);
        rd(`NFH_OFF_STATUS, v);
        chk(v & 32'h8, 32'h8);
        ready();
        rd(`NFH_OFF_STATUS, v);
        chk(v & 32'h4, 32'h0);
        get(32'h200000, 32'hffff);
        get(32'h080000, 32'h3c3c);
        rd(`NFH_OFF_STATUS, v);
        chk(v & 32'h18, 32'h18);
        wr(`NFH_OFF_STATUS, 32'h8);
        rd(`NFH_OFF_STATUS, v);
        chk(v & 32'h8, 32'h0);
        $display("test bank done");
    endtask
    task automatic t_prot;
        ctrl(32'h2);
        access(32'h000010, 32'h1234, 32'h2);
        get(32'h000010, 32'hffff);
        ctrl(32'h0);
        $display("test protect done");
    endtask
    task automatic t_rst;
        ctrl(32'h4);
        wr(`NFH_OFF_CMD, 32'h1);
        rd(`NFH_OFF_STATUS, v);
        chk(v & 32'h1, 32'h0);
        ctrl(32'h0);
        $display("test device reset done");
    endtask
    task automatic summarize;
        $display("checks=%0d errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 20000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_we = 1'b0;
        reg_re = 1'b0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        t_reset();
        t_word();
        t_byte();
        t_bank();
        t_prot();
        t_rst();
        summarize();
    end
endmodule
